// File: src/dcps_defines.svh
`ifndef DCPS_DEFINES_SVH
`define DCPS_DEFINES_SVH

// system bus windows, 8 words each
`define DCPS_PRI_BASE 20'h0ff10
`define DCPS_ALT_BASE 20'h0ff18
`define DCPS_WIN_LSB 3
`define DCPS_STAT_OFS_BIT 2
`define DCPS_BOOT_LIST 16'h0000

// embedded processor register windows
`define DCPS_CSR_MEM_PAGE 10'h180
`define DCPS_CSR_IO_PAGE 2'h0
`define DCPS_CSR_IDX_W 6

// list instruction opcodes
`define DCPS_OP_CMD 4'h1
`define DCPS_OP_STAT 4'h2
`define DCPS_OP_DIN 4'h3
`define DCPS_OP_DOUT 4'h4
`define DCPS_OP_END 4'hf

// drive command mode field and status flags
`define DCPS_CMD_MODE_HI 11
`define DCPS_CMD_MODE_LO 10
`define DCPS_CMD_READ 2'h1
`define DCPS_CMD_WRITE 2'h2
`define DCPS_STAT_FAULT 7

// timer vectors and timing
`define DCPS_VEC_BASE 8'h40
// idle trigger levels: dma and interval high, index and run timer low,
// so the edge detector sees no false edge straight after reset
`define DCPS_TRIG_IDLE 4'h9
`define DCPS_CLK_MHZ 20
`define DCPS_RUN_TIMER_US 100
`define DCPS_OP_LIMIT_US 500

`endif

// File: src/dcps_pkg.sv
package dcps_pkg;
    typedef enum {
        ST_IDLE, ST_FETCH, ST_EXEC, ST_DESC, ST_XIN, ST_XOUT
    } dcps_state_e;
    typedef enum logic [1:0] {MD_NONE, MD_READ, MD_WRITE} dcps_mode_e;
    typedef enum logic [1:0] {
        CODE_NONE, CODE_NORMAL, CODE_ABNORMAL, CODE_RESIDUAL
    } dcps_code_e;
    typedef struct packed {
        logic [3:0] op;
        logic [11:0] arg;
    } dcps_insn_s;
    typedef struct packed {
        logic [1:0] drive;
        dcps_code_e code;
        logic [7:0] resid;
    } dcps_stat_s;
endpackage

// File: src/dcps_seq.sv
`timescale 1ns/1ns
`include "dcps_defines.svh"
// Summary of operation
// - primary window decodes and answers bootstrap
// - alternate window decodes, ignores bootstrap
// - four drives, four independent concurrent tasks
// - list is contiguous, fetched in sequence
// - command, status, data, end instruction classes
// - inconsistent instruction ends task abnormally
// - read: seek, scan, read, verify, status
// - suspend after drive launch, resume when done
// - end of list posts status, terminates
// - unrecoverable error keeps residual status
// - one read/write/ecc path at a time
// - command cable carries no user data
// - registers reached via memory or io space
// - bus request and grant stay unused
// - four timer channels, channel 0 highest
// - per-channel unique interrupt vector
// - dma run falling edge on channel 0
// - index detected falling edge on channel 1
// - run timer expiry on channel 2
// - channel 3 interval limit plus diag strobe
// - register window in memory and io space

module dcps_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt != (AW+1)'(DEPTH);
    assign out_valid = cnt != '0;
    assign out_data = mem[rp];
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? wp + 1'b1 : wp;
            rp <= pop ? rp + 1'b1 : rp;
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module dcps_seq #(
    parameter int LIMIT_CYC = `DCPS_OP_LIMIT_US * `DCPS_CLK_MHZ,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic window_alt_sel,
    input wire logic [19:0] sys_addr,
    input wire logic sys_valid,
    input wire logic sys_write,
    input wire logic sys_boot,
    input wire logic [15:0] sys_wdata,
    output logic sys_ack,
    output logic [15:0] sys_rdata,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_rdy,
    input wire logic [15:0] mem_rdata,
    output logic drv_cmd_valid,
    output logic [1:0] drv_cmd_drive,
    output logic [11:0] drv_cmd,
    input wire logic [3:0] drv_done,
    input wire logic [7:0] drv_stat,
    input wire logic drv_rd_valid,
    output logic drv_rd_ready,
    input wire logic [15:0] drv_rd_data,
    output logic drv_wr_valid,
    output logic [15:0] drv_wr_data,
    output logic dma_valid,
    input wire logic dma_ready,
    output logic [15:0] dma_data,
    output logic [15:0] dma_addr,
    output logic stat_valid,
    output dcps_pkg::dcps_stat_s stat,
    output logic xfer_busy,
    input wire logic index_detected,
    input wire logic diag_timer_write_strobe,
    output logic cpu_int,
    input wire logic cpu_int_ack,
    output logic [7:0] cpu_vec,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_memory_request,
    input wire logic cpu_io_request,
    input wire logic cpu_bus_request,
    output logic cpu_bus_grant,
    output logic csr_hit,
    output logic [5:0] csr_index
);
    import dcps_pkg::*;
    localparam int RUN_CYC = `DCPS_RUN_TIMER_US * `DCPS_CLK_MHZ;

    function automatic logic [1:0] rr_pick(input logic [3:0] req,
                                           input logic [1:0] last);
        logic [1:0] idx;
        rr_pick = last;
        for (int k = 1; k <= 4; k++) begin
            idx = 2'(int'(last) + k);
            if (req[idx] && rr_pick == last && !req[last]) begin
                rr_pick = idx;
            end else if (req[idx] && idx != last && rr_pick == last) begin
                rr_pick = idx;
            end
        end
    endfunction

    function automatic logic [1:0] pri_enc(input logic [3:0] p);
        pri_enc = p[0] ? 2'd0 : p[1] ? 2'd1 : p[2] ? 2'd2 : 2'd3;
    endfunction

    dcps_state_e state;
    dcps_state_e next_state;
    logic alt_win;
    logic [3:0] active;
    logic [3:0] susp;
    logic [15:0] pc [4];
    dcps_mode_e mode [4];
    dcps_stat_s last_stat [4];
    logic [1:0] cur;
    dcps_insn_s insn;
    logic [15:0] buf_addr;
    logic [11:0] xcnt;

    // system bus window and host commands
    wire [19:0] win_base = alt_win ? `DCPS_ALT_BASE : `DCPS_PRI_BASE;
    wire win_hit = sys_valid && (sys_addr[19:`DCPS_WIN_LSB] ==
                   win_base[19:`DCPS_WIN_LSB]);
    wire [1:0] sys_drive = sys_addr[1:0];
    wire boot_go = win_hit && sys_boot && !alt_win;
    wire host_go = win_hit && sys_write && !sys_boot &&
                   !sys_addr[`DCPS_STAT_OFS_BIT] && !active[sys_drive];
    wire [1:0] start_drv = boot_go ? 2'd0 : sys_drive;
    wire [15:0] start_pc = boot_go ? `DCPS_BOOT_LIST : sys_wdata;
    wire start_go = boot_go || host_go;
    wire bus_answer = win_hit && (!sys_boot || !alt_win);

    // scheduler
    logic [3:0] ready;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rdy
            assign ready[gi] = active[gi] && (!susp[gi] || drv_done[gi]);
        end
    endgenerate
    wire [1:0] pick = rr_pick(ready, cur);

    // instruction decode
    wire [1:0] cmd_mode = insn.arg[`DCPS_CMD_MODE_HI:`DCPS_CMD_MODE_LO];
    wire in_exec = state == ST_EXEC;
    wire op_cmd = in_exec && insn.op == `DCPS_OP_CMD;
    wire op_stat = in_exec && insn.op == `DCPS_OP_STAT;
    wire op_din = in_exec && insn.op == `DCPS_OP_DIN;
    wire op_dout = in_exec && insn.op == `DCPS_OP_DOUT;
    wire op_end = in_exec && insn.op == `DCPS_OP_END;
    wire op_bad = in_exec && !(op_cmd || op_stat || op_din || op_dout ||
                  op_end);
    wire mis_din = op_din && mode[cur] != MD_READ;
    wire mis_dout = op_dout && mode[cur] != MD_WRITE;
    wire fault = op_stat && drv_stat[`DCPS_STAT_FAULT];
    wire abort = op_bad || mis_din || mis_dout;
    wire finish = op_end || abort || fault;
    wire fetch_ok = state == ST_FETCH && mem_rdy;
    wire desc_ok = state == ST_DESC && mem_rdy;
    wire fifo_ready;
    wire in_push = state == ST_XIN && drv_rd_valid && fifo_ready;
    wire out_word = state == ST_XOUT && mem_rdy;
    wire xfer_last = xcnt == 12'h001;
    wire xin_done = in_push && xfer_last;
    wire xout_done = out_word && xfer_last;
    wire dma_pop = dma_valid && dma_ready;

    // result code of a terminating instruction
    wire dcps_code_e fin_code = fault ? CODE_RESIDUAL :
                                abort ? CODE_ABNORMAL : CODE_NORMAL;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = |ready ? ST_FETCH : ST_IDLE;
            ST_FETCH: next_state = mem_rdy ? ST_EXEC : ST_FETCH;
            ST_EXEC: begin
                if (finish || op_cmd || op_stat) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_DESC;
                end
            end
            ST_DESC: begin
                if (!mem_rdy) begin
                    next_state = ST_DESC;
                end else if (insn.op == `DCPS_OP_DIN) begin
                    next_state = ST_XIN;
                end else begin
                    next_state = ST_XOUT;
                end
            end
            ST_XIN: next_state = xin_done ? ST_IDLE : ST_XIN;
            ST_XOUT: next_state = xout_done ? ST_IDLE : ST_XOUT;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            cur <= 2'd3;
            insn <= '0;
            buf_addr <= '0;
            xcnt <= '0;
        end else begin
            state <= next_state;
            cur <= (state == ST_IDLE && |ready) ? pick : cur;
            insn <= fetch_ok ? dcps_insn_s'(mem_rdata) : insn;
            buf_addr <= desc_ok ? mem_rdata : buf_addr;
            if (in_exec) begin
                xcnt <= insn.arg;
            end else if (in_push || out_word) begin
                xcnt <= xcnt - 12'h001;
            end
        end
    end

    // strap sampled on every clock, in reset or not
    always_ff @(posedge core_clk) begin
        alt_win <= window_alt_sel;
    end

    // per-drive task state
    generate
        for (gi = 0; gi < 4; gi++) begin : g_task
            wire mine = cur == 2'(gi);
            wire go = start_go && start_drv == 2'(gi);
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    active[gi] <= 1'b0;
                    susp[gi] <= 1'b0;
                    pc[gi] <= '0;
                    mode[gi] <= MD_NONE;
                    last_stat[gi] <= '0;
                end else if (go) begin
                    active[gi] <= 1'b1;
                    susp[gi] <= 1'b0;
                    pc[gi] <= start_pc;
                    mode[gi] <= MD_NONE;
                end else if (mine && state == ST_IDLE && |ready &&
                             pick == 2'(gi)) begin
                    susp[gi] <= 1'b0;
                end else if (mine && in_exec) begin
                    active[gi] <= !finish;
                    susp[gi] <= op_cmd;
                    pc[gi] <= pc[gi] + ((op_din || op_dout) ? 16'h0002 :
                                                               16'h0001);
                    if (op_cmd && cmd_mode == `DCPS_CMD_READ) begin
                        mode[gi] <= MD_READ;
                    end else if (op_cmd && cmd_mode == `DCPS_CMD_WRITE) begin
                        mode[gi] <= MD_WRITE;
                    end
                    if (finish || op_stat) begin
                        last_stat[gi] <= {2'(gi), fin_code, drv_stat};
                    end
                end
            end
        end
    endgenerate

    // memory port shared by list fetch and outbound data
    always_comb begin
        mem_req = 1'b0;
        mem_addr = pc[cur];
        case (state)
            ST_FETCH: mem_req = 1'b1;
            ST_DESC: begin
                mem_req = 1'b1;
                mem_addr = pc[cur] - 16'h0001;
            end
            ST_XOUT: begin
                mem_req = 1'b1;
                mem_addr = buf_addr + 16'(insn.arg - xcnt);
            end
            default: mem_req = 1'b0;
        endcase
    end

    // one transfer path for all drives; the fsm can only be in one
    assign xfer_busy = state == ST_XIN || state == ST_XOUT;
    assign drv_rd_ready = state == ST_XIN && fifo_ready;

    dcps_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(state == ST_XIN && drv_rd_valid),
        .in_ready(fifo_ready),
        .in_data(drv_rd_data),
        .out_valid(dma_valid),
        .out_ready(dma_ready),
        .out_data(dma_data)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drv_cmd_valid <= 1'b0;
            drv_cmd_drive <= '0;
            drv_cmd <= '0;
            drv_wr_valid <= 1'b0;
            drv_wr_data <= '0;
            dma_addr <= '0;
            stat_valid <= 1'b0;
            stat <= '0;
            sys_ack <= 1'b0;
            sys_rdata <= '0;
        end else begin
            drv_cmd_valid <= op_cmd;
            drv_cmd_drive <= op_cmd ? cur : drv_cmd_drive;
            drv_cmd <= op_cmd ? insn.arg : drv_cmd;
            drv_wr_valid <= out_word;
            drv_wr_data <= out_word ? mem_rdata : drv_wr_data;
            // dma address follows the drain, not the fill
            if (desc_ok) begin
                dma_addr <= mem_rdata;
            end else if (dma_pop) begin
                dma_addr <= dma_addr + 16'h0001;
            end
            stat_valid <= finish;
            stat <= finish ? dcps_stat_s'({cur, fin_code, drv_stat}) : stat;
            sys_ack <= bus_answer;
            sys_rdata <= 16'(last_stat[sys_drive]);
        end
    end

    // counter timer unit
    logic [15:0] run_cnt;
    logic [$clog2(LIMIT_CYC+1)-1:0] iv_cnt;
    logic [3:0] trig_q;
    logic [3:0] pend;
    wire run_alive = run_cnt != '0;
    wire iv_exp = iv_cnt == '0 && |susp;
    wire [3:0] trig = {!(iv_exp || diag_timer_write_strobe),
                       run_alive,
                       index_detected,
                       !dma_valid};
    wire [3:0] fall = trig_q & ~trig;
    wire [1:0] ack_ch = pri_enc(pend);
    wire [3:0] clr = cpu_int_ack ? 4'(1) << ack_ch : 4'h0;
    assign cpu_int = |pend;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            run_cnt <= '0;
            iv_cnt <= '0;
            trig_q <= `DCPS_TRIG_IDLE;
            pend <= '0;
            cpu_vec <= '0;
        end else begin
            run_cnt <= fetch_ok ? 16'(RUN_CYC) :
                       run_alive ? run_cnt - 16'h0001 : run_cnt;
            if (!(|susp)) begin
                iv_cnt <= ($bits(iv_cnt))'(LIMIT_CYC);
            end else if (iv_cnt != '0) begin
                iv_cnt <= iv_cnt - 1'b1;
            end
            trig_q <= trig;
            pend <= (pend & ~clr) | fall; // new edge beats the clear
            if (cpu_int_ack) begin
                cpu_vec <= `DCPS_VEC_BASE | 8'({ack_ch, 1'b0});
            end
        end
    end

    // embedded processor register window
    assign csr_hit = (cpu_memory_request &&
                      cpu_addr[15:6] == `DCPS_CSR_MEM_PAGE) ||
                     (cpu_io_request &&
                      cpu_addr[7:6] == `DCPS_CSR_IO_PAGE);
    assign csr_index = cpu_addr[`DCPS_CSR_IDX_W-1:0];
    // processor never yields its bus; the request input is ignored
    assign cpu_bus_grant = 1'b0;

    property p_alt_no_boot;
        @(posedge core_clk) disable iff (!rstn)
        (alt_win && sys_boot && win_hit) |=> !sys_ack && !active[0];
    endproperty
    a_alt_no_boot: assert property (p_alt_no_boot)
        else $error("alternate window answered bootstrap");

    property p_pri_boot;
        @(posedge core_clk) disable iff (!rstn)
        (!alt_win && sys_boot && win_hit) |=> sys_ack && active[0];
    endproperty
    a_pri_boot: assert property (p_pri_boot)
        else $error("primary window ignored bootstrap");

    property p_cmd_suspends;
        @(posedge core_clk) disable iff (!rstn)
        op_cmd && !start_go |=> drv_cmd_valid && susp[drv_cmd_drive]
            && state == ST_IDLE;
    endproperty
    a_cmd_suspends: assert property (p_cmd_suspends)
        else $error("drive command did not suspend the task");

    property p_mismatch_abn;
        @(posedge core_clk) disable iff (!rstn)
        (mis_din || mis_dout) |=> stat_valid &&
            stat.code == CODE_ABNORMAL && !xfer_busy;
    endproperty
    a_mismatch_abn: assert property (p_mismatch_abn)
        else $error("inconsistent transfer not ended abnormally");

    property p_end_posts;
        @(posedge core_clk) disable iff (!rstn)
        op_end && !start_go |=> stat_valid && stat.code == CODE_NORMAL
            && stat.resid == $past(drv_stat) && !active[stat.drive];
    endproperty
    a_end_posts: assert property (p_end_posts)
        else $error("end of list did not post status");

    property p_one_path;
        @(posedge core_clk) disable iff (!rstn)
        drv_wr_valid |-> $past(state) == ST_XOUT && !drv_rd_ready;
    endproperty
    a_one_path: assert property (p_one_path)
        else $error("read and write paths active together");

    property p_ch0_vec;
        @(posedge core_clk) disable iff (!rstn)
        cpu_int_ack && pend[0] |=> cpu_vec == `DCPS_VEC_BASE;
    endproperty
    a_ch0_vec: assert property (p_ch0_vec)
        else $error("channel 0 vector wrong");

    property p_fall_int;
        @(posedge core_clk) disable iff (!rstn)
        |fall |=> cpu_int;
    endproperty
    a_fall_int: assert property (p_fall_int)
        else $error("timer edge raised no interrupt");

    property p_io_window;
        @(posedge core_clk) disable iff (!rstn)
        cpu_io_request && !cpu_memory_request && cpu_addr[7:6] != 2'h0
            |-> !csr_hit;
    endproperty
    a_io_window: assert property (p_io_window)
        else $error("io decode outside its window");
endmodule

// File: sim/dcps_host_mem.sv
`timescale 1ns/1ns
module dcps_host_mem (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_rdy,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [0:63];
    logic [2:0] cnt;
    wire [2:0] lat = slow ? 3'h4 : 3'h0;
    // words come back from the requested address only, in order
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 3'h0;
            mem_rdy <= 1'b0;
            mem_rdata <= 16'h0;
        end else if (mem_req && !mem_rdy && cnt >= lat) begin
            cnt <= 3'h0;
            mem_rdy <= 1'b1;
            mem_rdata <= mem[mem_addr[5:0]];
        end else begin
            // data not valid outside the strobe: keep it moving
            cnt <= (mem_req && !mem_rdy) ? cnt + 3'h1 : 3'h0;
            mem_rdy <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    import dcps_pkg::*;
    logic core_clk, rstn, window_alt_sel, sys_valid, sys_write, sys_boot;
    logic [19:0] sys_addr;
    logic [15:0] sys_wdata, sys_rdata, mem_addr, mem_rdata, drv_rd_data;
    logic [15:0] drv_wr_data, dma_data, dma_addr, cpu_addr;
    logic sys_ack, mem_req, mem_rdy, drv_cmd_valid, drv_rd_valid;
    logic drv_rd_ready, drv_wr_valid, dma_valid, dma_ready, stat_valid;
    logic xfer_busy, index_detected, diag_timer_write_strobe, cpu_int;
    logic cpu_int_ack, cpu_memory_request, cpu_io_request, cpu_bus_request;
    logic cpu_bus_grant, csr_hit, slow, stream_on;
    logic [1:0] drv_cmd_drive;
    logic [11:0] drv_cmd;
    logic [3:0] drv_done;
    logic [7:0] drv_stat, cpu_vec;
    logic [5:0] csr_index;
    dcps_stat_s stat;
    int n_errors, tests_run, cyc, rd_cnt, pops, wr_cnt;

    dcps_seq #(.LIMIT_CYC(50), .FIFO_DEPTH(16)) dut (
        .core_clk, .rstn, .window_alt_sel, .sys_addr, .sys_valid,
        .sys_write, .sys_boot, .sys_wdata, .sys_ack, .sys_rdata, .mem_req,
        .mem_addr, .mem_rdy, .mem_rdata, .drv_cmd_valid, .drv_cmd_drive,
        .drv_cmd, .drv_done, .drv_stat, .drv_rd_valid, .drv_rd_ready,
        .drv_rd_data, .drv_wr_valid, .drv_wr_data, .dma_valid, .dma_ready,
        .dma_data, .dma_addr, .stat_valid, .stat, .xfer_busy,
        .index_detected, .diag_timer_write_strobe, .cpu_int, .cpu_int_ack,
        .cpu_vec, .cpu_addr, .cpu_memory_request, .cpu_io_request,
        .cpu_bus_request, .cpu_bus_grant, .csr_hit, .csr_index
    );
    dcps_host_mem host (.core_clk, .rstn, .slow, .mem_req, .mem_addr,
        .mem_rdy, .mem_rdata);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic sys_req(input logic [19:0] a, input logic w, b,
            input logic [15:0] d, input logic ack);
        @(posedge core_clk);
        sys_addr <= a;
        sys_write <= w;
        sys_boot <= b;
        sys_wdata <= d;
        sys_valid <= 1'b1;
        @(posedge core_clk);
        sys_valid <= 1'b0;
        #1;
        chk(sys_ack, ack);
    endtask

    task automatic wait_stat();
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            #1;
            i++;
        end while (stat_valid !== 1'b1 && i < 400);
    endtask

    task automatic wait_cmd();
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            #1;
            i++;
        end while (drv_cmd_valid !== 1'b1 && i < 400);
    endtask

    task automatic ack_vec(input logic [7:0] v);
        @(posedge core_clk);
        cpu_int_ack <= 1'b1;
        @(posedge core_clk);
        cpu_int_ack <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(cpu_vec, v);
    endtask

    task automatic csr(input logic m, io, input logic [15:0] a, h);
        @(posedge core_clk);
        cpu_memory_request <= m;
        cpu_io_request <= io;
        cpu_addr <= a;
        @(posedge core_clk);
        #1;
        chk({csr_hit, csr_index}, {h[0], a[5:0]});
    endtask

    task automatic t_timer();
        @(posedge core_clk);
        index_detected <= 1'b1;
        diag_timer_write_strobe <= 1'b1;
        @(posedge core_clk);
        index_detected <= 1'b0;
        diag_timer_write_strobe <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk(cpu_int, 1'b1);
        ack_vec(8'h42);
        ack_vec(8'h46);
        chk(cpu_int, 1'b0);
    endtask

    task automatic t_csr();
        cpu_bus_request <= 1'b1;
        csr(1'b1, 1'b0, 16'h6000, 1);
        csr(1'b1, 1'b0, 16'h603f, 1);
        csr(1'b1, 1'b0, 16'h6040, 0);
        csr(1'b0, 1'b1, 16'hff3f, 1);
        csr(1'b0, 1'b1, 16'h0040, 0);
        csr(1'b0, 1'b0, 16'h6000, 0);
        chk(cpu_bus_grant, 1'b0);
    endtask

    task automatic t_boot();
        drv_stat <= 8'h05;
        sys_req(20'h0ff10, 1'b0, 1'b1, 16'h0, 1'b1);
        wait_stat();
        chk(stat, {2'd0, CODE_NORMAL, 8'h05});
    endtask

    task automatic t_alt();
        window_alt_sel <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_req(20'h0ff18, 1'b0, 1'b1, 16'h0, 1'b0);
        sys_req(20'h0ff12, 1'b1, 1'b0, 16'h8, 1'b0);
        sys_req(20'h0ff1a, 1'b1, 1'b0, 16'h8, 1'b1);
        wait_cmd();
        chk({drv_cmd_drive, drv_cmd}, {2'd2, 12'h800});
        drv_done <= 4'h4;
        wait_stat();
        chk(stat[11:8], {2'd2, CODE_ABNORMAL});
        window_alt_sel <= 1'b0;
    endtask

    task automatic t_fault();
        drv_stat <= 8'h81;
        sys_req(20'h0ff11, 1'b1, 1'b0, 16'h10, 1'b1);
        wait_stat();
        chk(stat, {2'd1, CODE_RESIDUAL, 8'h81});
        sys_req(20'h0ff15, 1'b0, 1'b0, 16'h0, 1'b1);
        chk(sys_rdata, 16'h0781);
    endtask

    task automatic t_write();
        drv_done <= 4'hd;
        sys_req(20'h0ff10, 1'b1, 1'b0, 16'h20, 1'b1);
        wait_stat();
        chk(wr_cnt, 2);
        chk(stat, {2'd0, CODE_NORMAL, 8'h00});
    endtask

    // run timer lapses once no list word has been fetched for a while
    task automatic t_run();
        repeat (2100) @(posedge core_clk);
        ack_vec(8'h44);
        chk(cpu_int, 1'b0);
    endtask

    // slow memory; drive holds data while the buffer is full
    task automatic t_read();
        drv_stat <= 8'h00;
        slow <= 1'b1;
        sys_req(20'h0ff13, 1'b1, 1'b0, 16'h18, 1'b1);
        wait_cmd();
        chk({drv_cmd_drive, drv_cmd}, {2'd3, 12'h400});
        repeat (20) @(posedge core_clk);
        #1;
        chk(mem_req, 1'b0);
        drv_done <= 4'hc;
        stream_on <= 1'b1;
        repeat (120) @(posedge core_clk);
        chk(rd_cnt, 16);
        chk(xfer_busy, 1'b1);
        ack_vec(8'h40);
        dma_ready <= 1'b1;
        wait_stat();
        chk(pops, 20);
        chk(stat, {2'd3, CODE_NORMAL, 8'h00});
    endtask

    always @(posedge core_clk) begin
        drv_rd_valid <= stream_on &&
            rd_cnt + int'(drv_rd_valid && drv_rd_ready) < 20;
        if (drv_rd_valid && drv_rd_ready) begin
            rd_cnt <= rd_cnt + 1;
        end
        if (dma_valid && dma_ready) begin
            chk(dma_data, 16'ha000 + pops[15:0]);
            if (pops == 0) begin
                chk(dma_addr, 16'h0100);
            end
            pops <= pops + 1;
        end
        if (drv_wr_valid) begin
            chk(drv_wr_data, 16'h5a00 + wr_cnt[15:0]);
            wr_cnt <= wr_cnt + 1;
        end
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            n_errors++;
            close_out();
        end
    end
    assign drv_rd_data = 16'ha000 + rd_cnt[15:0];

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        {rstn, window_alt_sel, sys_valid, sys_write, sys_boot, sys_addr,
            sys_wdata, drv_done, drv_stat, dma_ready, index_detected,
            diag_timer_write_strobe, cpu_int_ack, cpu_addr, slow,
            cpu_memory_request, cpu_io_request, cpu_bus_request,
            stream_on} = '0;
        {n_errors, tests_run, cyc, rd_cnt, pops, wr_cnt} = '0;
        host.mem[0] = 16'hf000;
        host.mem[8] = 16'h1800;
        host.mem[9] = 16'h3001;
        host.mem[16] = 16'h2000;
        host.mem[17] = 16'hf000;
        host.mem[24] = 16'h1400;
        host.mem[25] = 16'h3014;
        host.mem[26] = 16'h0100;
        host.mem[27] = 16'h2000;
        host.mem[28] = 16'hf000;
        host.mem[32] = 16'h1800;
        host.mem[33] = 16'h4002;
        host.mem[34] = 16'h0028;
        host.mem[35] = 16'hf000;
        host.mem[40] = 16'h5a00;
        host.mem[41] = 16'h5a01;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_timer();
        t_csr();
        t_boot();
        t_alt();
        t_fault();
        t_read();
        t_write();
        t_run();
        close_out();
    end
endmodule
